/* shared/stop_ramp_map.svh */
`ifndef STOP_RAMP_MAP_SVH
`define STOP_RAMP_MAP_SVH
`define FREQ_MAX_CENTI        16'he9fc
`define DELAY_MAX_CENTI       16'hea60
`define STOP_METHOD_POSITION  3'h4
`define STOP_METHOD_RAMP      3'h0
`define STOP_METHOD_COAST     3'h1
`define TICK_TIME_NS          10000000
`define CLK_PERIOD_NS         40
`define TICK_CYCLES           (`TICK_TIME_NS / `CLK_PERIOD_NS)
`define THR_RESET_0           16'h0000
`define THR_RESET_1           16'h01f4
`define THR_RESET_2           16'h03e8
`define THR_RESET_3           16'h07d0
`define THR_RESET_4           16'h0bb8
`define THR_RESET_5           16'h0fa0
`define THR_RESET_6           16'h1388
`define THR_RESET_7           16'h1770
`endif

/* shared/stop_ramp_pkg.sv */
package stop_ramp_pkg;
    typedef enum logic [2:0] {
        ST_RUN,
        ST_HOLD,
        ST_DECEL,
        ST_COAST,
        ST_STOPPED
    } phase_t;

    typedef struct packed {
        logic [3:0]  idx;
        logic [15:0] value;
        logic        thr_we;
        logic        dly_we;
    } param_wr_t;
endpackage

/* design/positioning_stop_ramp_control.sv */
// How it works
// - With smoothing enabled the ramp lasts longer than the base time, by the smoothing value.
// - Total acceleration time is the selected accel time (set one or two) plus accel smoothing.
// - Total deceleration time is the selected decel time (set one or two) plus decel smoothing.
// - Eight stop frequency thresholds, 0 to 599.00 Hz in 0.01 Hz steps, are held.
// - Eight hold delays, 0 to 600.00 s in 0.01 s steps, default zero, are held.
// - With method 4 a stop command does a positioning stop and an external fault coasts.
// - Threshold n is paired with hold delay n.
// - After a positioning stop command the frequency is held until the delay ends, then decels.
// - A coast stop removes the output at once.
`timescale 1ns/1ps
`default_nettype none
`include "stop_ramp_map.svh"
module positioning_stop_ramp_control
    import stop_ramp_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Ramp settings, 0.01 s units
    input  wire logic [15:0] accel_time_set_one,
    input  wire logic [15:0] decel_time_set_one,
    input  wire logic [15:0] accel_time_set_two,
    input  wire logic [15:0] decel_time_set_two,
    input  wire logic [15:0] accel_smoothing_curve,
    input  wire logic [15:0] decel_smoothing_curve,
    input  wire logic        time_set_two_sel,
    input  wire logic [2:0]  stop_method_select,
    // Parameter writes
    input  wire param_wr_t   param_wr,
    // Commands and running frequency, 0.01 Hz units
    input  wire logic        stop_cmd,
    input  wire logic        ext_fault,
    input  wire logic [15:0] run_freq,
    // Status
    output logic [16:0]      total_accel_time,
    output logic [16:0]      total_decel_time,
    output logic             output_enable,
    output logic             freq_hold,
    output logic             decel_active,
    output logic [15:0]      hold_remaining,
    output logic [15:0]      thr_read,
    output logic [15:0]      dly_read
);
    logic [15:0] thr_q [8];
    logic [15:0] dly_q [8];
    phase_t      phase_q;
    logic [31:0] tick_q;
    logic [15:0] hold_q;

    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lim);
        clamp = (v > lim) ? lim : v;
    endfunction

    // Band lookup: first threshold at or above the running frequency
    logic [2:0]  band_idx;
    always_comb begin
        band_idx = 3'h7;
        for (int i = 7; i >= 0; i--) begin
            if (run_freq <= thr_q[i]) begin
                band_idx = i[2:0];
            end
        end
    end

    wire logic [15:0] band_thr = thr_q[band_idx];
    wire logic [15:0] band_dly = dly_q[band_idx];
    // Proportional scaling below the band threshold; a zero threshold gives the full band delay
    wire logic [31:0] scaled_prod = 32'(band_dly) * 32'(run_freq);
    wire logic [31:0] scaled_quot = (band_thr == 16'h0000) ? 32'h0 :
                                    scaled_prod / 32'(band_thr);
    wire logic [15:0] hold_start = (run_freq >= band_thr) ? band_dly :
                                   scaled_quot[15:0];

    wire logic pos_mode = (stop_method_select == `STOP_METHOD_POSITION);
    wire logic coast_on_stop = (stop_method_select == `STOP_METHOD_COAST) ||
                               (stop_method_select == 3'h3);
    wire logic coast_on_fault = pos_mode || (stop_method_select == `STOP_METHOD_RAMP) ||
                                (stop_method_select == `STOP_METHOD_COAST);
    wire logic tick_hit = (tick_q == 32'(TICK_CYCLES - 1));

    wire logic [15:0] acc_base = time_set_two_sel ? accel_time_set_two : accel_time_set_one;
    wire logic [15:0] dec_base = time_set_two_sel ? decel_time_set_two : decel_time_set_one;

    // Parameter storage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            thr_q[0] <= `THR_RESET_0;
            thr_q[1] <= `THR_RESET_1;
            thr_q[2] <= `THR_RESET_2;
            thr_q[3] <= `THR_RESET_3;
            thr_q[4] <= `THR_RESET_4;
            thr_q[5] <= `THR_RESET_5;
            thr_q[6] <= `THR_RESET_6;
            thr_q[7] <= `THR_RESET_7;
            for (int i = 0; i < 8; i++) begin
                dly_q[i] <= 16'h0000;
            end
        end else if (!param_wr.idx[3]) begin
            if (param_wr.thr_we) begin
                thr_q[param_wr.idx[2:0]] <= clamp(param_wr.value, `FREQ_MAX_CENTI);
            end
            if (param_wr.dly_we) begin
                dly_q[param_wr.idx[2:0]] <= clamp(param_wr.value, `DELAY_MAX_CENTI);
            end
        end
    end

    // Stop sequencing
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_q <= ST_RUN;
            tick_q  <= 32'h0;
            hold_q  <= 16'h0000;
        end else begin
            case (phase_q)
                ST_RUN: begin
                    tick_q <= 32'h0;
                    if (ext_fault) begin
                        phase_q <= coast_on_fault ? ST_COAST : ST_DECEL;
                    end else if (stop_cmd) begin
                        if (pos_mode) begin
                            hold_q  <= hold_start;
                            phase_q <= (hold_start == 16'h0000) ? ST_DECEL : ST_HOLD;
                        end else begin
                            phase_q <= coast_on_stop ? ST_COAST : ST_DECEL;
                        end
                    end
                end
                ST_HOLD: begin
                    if (ext_fault) begin
                        phase_q <= ST_COAST;
                    end else if (tick_hit) begin
                        tick_q <= 32'h0;
                        hold_q <= hold_q - 16'h0001;
                        if (hold_q == 16'h0001) begin
                            phase_q <= ST_DECEL;
                        end
                    end else begin
                        tick_q <= tick_q + 32'h1;
                    end
                end
                ST_DECEL: begin
                    if (ext_fault && coast_on_fault) begin
                        phase_q <= ST_COAST;
                    end else if (run_freq == 16'h0000) begin
                        phase_q <= ST_STOPPED;
                    end
                end
                ST_COAST: begin
                    phase_q <= ST_STOPPED;
                end
                default: begin
                    if (!stop_cmd && !ext_fault) begin
                        phase_q <= ST_RUN;
                    end
                end
            endcase
        end
    end

    // Registered status outputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            total_accel_time <= 17'h0;
            total_decel_time <= 17'h0;
            output_enable    <= 1'b0;
            freq_hold        <= 1'b0;
            decel_active     <= 1'b0;
            hold_remaining   <= 16'h0000;
            thr_read         <= 16'h0000;
            dly_read         <= 16'h0000;
        end else begin
            total_accel_time <= 17'(acc_base) + 17'(accel_smoothing_curve);
            total_decel_time <= 17'(dec_base) + 17'(decel_smoothing_curve);
            output_enable    <= (phase_q != ST_COAST) && (phase_q != ST_STOPPED);
            freq_hold        <= (phase_q == ST_HOLD);
            decel_active     <= (phase_q == ST_DECEL);
            hold_remaining   <= hold_q;
            thr_read         <= thr_q[param_wr.idx[2:0]];
            dly_read         <= dly_q[param_wr.idx[2:0]];
        end
    end

    hold_then_decel_a: assert property (@(posedge clk) disable iff (!rstn)
        (phase_q == ST_HOLD && hold_q == 16'h0001 && tick_hit && !ext_fault)
        |=> phase_q == ST_DECEL) else $error("hold did not end in decel");
    hold_steady_a: assert property (@(posedge clk) disable iff (!rstn)
        (phase_q == ST_HOLD && !ext_fault && !(tick_hit && hold_q == 16'h0001))
        |=> phase_q == ST_HOLD && !decel_active) else $error("hold ended early");
    hold_load_a: assert property (@(posedge clk) disable iff (!rstn)
        (phase_q == ST_RUN && !ext_fault && stop_cmd && pos_mode && run_freq >= band_thr)
        |=> hold_q == $past(band_dly)) else $error("hold not paired with band");
    coast_off_a: assert property (@(posedge clk) disable iff (!rstn)
        (phase_q == ST_COAST) |=> !output_enable) else $error("coast kept output");
    stopped_off_a: assert property (@(posedge clk) disable iff (!rstn)
        (phase_q == ST_STOPPED) |=> !output_enable) else $error("stopped kept output");
    fault_coast_a: assert property (@(posedge clk) disable iff (!rstn)
        (phase_q == ST_RUN && ext_fault && pos_mode) |=> phase_q == ST_COAST)
        else $error("fault did not coast");
    // Sums are only due after an edge that ran out of reset
    accel_sum_a: assert property (@(posedge clk) disable iff (!rstn)
        $past(rstn) |-> total_accel_time ==
        17'($past(acc_base)) + 17'($past(accel_smoothing_curve)))
        else $error("accel total wrong");
    decel_sum_a: assert property (@(posedge clk) disable iff (!rstn)
        $past(rstn) |-> total_decel_time ==
        17'($past(dec_base)) + 17'($past(decel_smoothing_curve)))
        else $error("decel total wrong");
    thr_range_a: assert property (@(posedge clk) disable iff (!rstn)
        thr_q[band_idx] <= `FREQ_MAX_CENTI) else $error("threshold out of range");
    dly_range_a: assert property (@(posedge clk) disable iff (!rstn)
        dly_q[band_idx] <= `DELAY_MAX_CENTI) else $error("delay out of range");
    hold_scale_a: assert property (@(posedge clk) disable iff (!rstn)
        hold_start <= band_dly) else $error("scaled delay above band delay");
endmodule
`default_nettype wire

/* bench/motor_load_model.sv */
`timescale 1ns/1ps
`default_nettype none
module motor_load_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Drive side
    input  wire logic        output_enable,
    input  wire logic        decel_active,
    input  wire logic [15:0] target_freq,
    // Shaft speed, 0.01 Hz
    output logic [15:0]      run_freq
);
    localparam logic [15:0] STEP = 16'h0100;
    logic [15:0] speed_q;
    logic [15:0] speed_d;
    wire         drive_up = output_enable && !decel_active;
    // Inertia as a fixed slope; free run and ramp-down both shed speed alike
    always_comb begin
        if (drive_up)
            speed_d = (target_freq > speed_q + STEP) ? speed_q + STEP : target_freq;
        else
            speed_d = (speed_q > STEP) ? speed_q - STEP : 16'h0000;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) speed_q <= 16'h0000;
        else       speed_q <= speed_d;
    end
    assign run_freq = speed_q;
endmodule
`default_nettype wire

/* bench/positioning_stop_ramp_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "stop_ramp_map.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected at %0t: value mismatch", $time); end end
module positioning_stop_ramp_control_test import stop_ramp_pkg::*;;
    localparam int TK = 4;
    logic clk, rstn, sel, stop_cmd, ext_fault, oe, hold, decel;
    logic [15:0] a1, d1, a2, d2, asc, dsc, run_freq, tgt, thr_read, dly_read, hrem;
    logic [2:0]  meth;
    logic [16:0] tot_a, tot_d;
    param_wr_t   pw;
    int fail_count, cmp_count;
    logic [15:0] thr_rst [8] = '{16'h0000, 16'h01f4, 16'h03e8, 16'h07d0,
                                 16'h0bb8, 16'h0fa0, 16'h1388, 16'h1770};
    positioning_stop_ramp_control #(.TICK_CYCLES(TK)) i_dut (.clk(clk), .rstn(rstn),
        .accel_time_set_one(a1), .decel_time_set_one(d1), .accel_time_set_two(a2),
        .decel_time_set_two(d2), .accel_smoothing_curve(asc), .decel_smoothing_curve(dsc),
        .time_set_two_sel(sel), .stop_method_select(meth), .param_wr(pw),
        .stop_cmd(stop_cmd), .ext_fault(ext_fault), .run_freq(run_freq),
        .total_accel_time(tot_a), .total_decel_time(tot_d), .output_enable(oe),
        .freq_hold(hold), .decel_active(decel), .hold_remaining(hrem),
        .thr_read(thr_read), .dly_read(dly_read));
    motor_load_model i_motor (.clk(clk), .rstn(rstn), .output_enable(oe),
        .decel_active(decel), .target_freq(tgt), .run_freq(run_freq));
    always #20 clk = ~clk;
    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [3:0] i, input logic [15:0] v, input logic t);
        @(posedge clk) pw <= '{i, v, t, !t};
        @(posedge clk) begin pw.thr_we <= 1'b0; pw.dly_we <= 1'b0; end
    endtask
    task automatic rd(input logic [3:0] i, input logic [15:0] et, input logic [15:0] ed);
        @(posedge clk) pw.idx <= i;
        @(posedge clk) #1;
        `CHK(thr_read, et)
        `CHK(dly_read, ed)
    endtask
    task automatic ramp(input logic s);
        @(posedge clk) sel <= s;
        repeat (2) @(posedge clk);
        #1;
        `CHK(tot_a, s ? 17'h0ee48 : 17'h007d0)
        `CHK(tot_d, s ? 17'h0012c : 17'h00898)
    endtask
    task automatic stop_run(input logic [15:0] f, input int cyc);
        int n;
        n = 0;
        @(posedge clk) tgt <= f;
        repeat (20) @(posedge clk);
        stop_cmd <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHK(hold, cyc > 0)
        `CHK(hrem, 16'(cyc / TK))
        while (hold === 1'b1 && n < 200) begin
            `CHK(decel, 1'b0)
            n++;
            @(posedge clk) #1;
        end
        `CHK(n, cyc)
        `CHK(decel, 1'b1)
        repeat (20) @(posedge clk);
        #1;
        `CHK(oe, 1'b0)
        @(posedge clk) stop_cmd <= 1'b0;
    endtask
    // e high: the method ramps down, so the output stays on and decel shows
    task automatic coast(input logic [2:0] m, input logic s, input logic f, input logic e);
        @(posedge clk) begin meth <= m; tgt <= 16'h07d0; end
        repeat (20) @(posedge clk);
        begin stop_cmd <= s; ext_fault <= f; end
        repeat (2) @(posedge clk);
        #1;
        `CHK(oe, e)
        `CHK(decel, e)
        `CHK(hold, 1'b0)
        @(posedge clk) begin stop_cmd <= 1'b0; ext_fault <= 1'b0; end
    endtask
    initial begin
        #200000;
        fail_count++;
        end_sim;
    end
    initial begin
        clk = 0; rstn = 0; sel = 0; stop_cmd = 0; ext_fault = 0; meth = `STOP_METHOD_RAMP;
        a1 = 16'h03e8; d1 = 16'h07d0; a2 = 16'hea60; d2 = 16'h0064;
        asc = 16'h03e8; dsc = 16'h00c8; tgt = 16'h0000; pw = '0;
        fail_count = 0; cmp_count = 0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 8; i++) rd(4'(i), thr_rst[i], 16'h0000);
        ramp(1'b0);
        ramp(1'b1);
        // Positioning mode is chosen before any threshold or delay is touched
        @(posedge clk) meth <= `STOP_METHOD_POSITION;
        wr(4'h8, 16'h0123, 1'b1);
        rd(4'h0, 16'h0000, 16'h0000);
        // Only the top threshold is raised, so the order holds and no two tie
        wr(4'h7, 16'hffff, 1'b1);
        wr(4'h7, 16'hffff, 1'b0);
        rd(4'h7, `FREQ_MAX_CENTI, `DELAY_MAX_CENTI);
        wr(4'h3, 16'h0004, 1'b0);
        wr(4'h2, 16'h0008, 1'b0);
        stop_run(16'h07d0, 4 * TK);
        stop_run(16'h05dc, 3 * TK);
        coast(`STOP_METHOD_POSITION, 1'b0, 1'b1, 1'b0);
        coast(`STOP_METHOD_COAST, 1'b1, 1'b0, 1'b0);
        // Method 0 on a stop and method 2 on a fault must not drop the output
        coast(`STOP_METHOD_RAMP, 1'b1, 1'b0, 1'b1);
        coast(3'h2, 1'b0, 1'b1, 1'b1);
        end_sim;
    end
endmodule
`default_nettype wire
